// file: include/rx_frame_pkg.sv
// Constants, register map and header carrier for the explicit receive frame builder.
// Assumes one AHB-Lite master and a byte sink on the same clock.
// Summary of operation
// (R1) Data packet frames go out only when output options bit 1 is set.
// (R2) Every frame starts with a one-byte start marker at offset 0.
// (R3) Length at offsets 1-2 counts bytes after length, before checksum.
// (R4) Byte at offset 3 is the frame type code 0x91.
// (R5) Sender 64-bit long address occupies offsets 4 through 11.
// (R6) Sender 16-bit short address occupies offsets 12 and 13.
// (R7) Source endpoint at offset 14, destination endpoint at offset 15.
// (R8) Cluster identifier at offset 16, profile identifier at offset 18.
// (R9) Options byte at 20: 0x01 acknowledged, 0x02 broadcast, 0x04 all-network broadcast.
// (R10) Options 0x10 marks secure session, 0x20 application-layer encryption.
// (R11) Options bits 7:6 give delivery method; 00 invalid, 01, 10, 11 valid.
// (R12) Option flags combine freely; host decodes each bit alone.
// (R13) Option flags describe packets using vendor endpoints 0xDC to 0xEE.
// (R14) Payload bytes start at offset 21 and end before the checksum.
// (R15) Checksum is 0xFF minus low byte of sum from offset 3 onward.
// (R16) Same frame type also carries device-object command responses.
// (R17) Device-object responses go out only when output options bit 0 is set.
// (R18) Device-object payload little-endian; all other multi-byte fields big-endian.
// (R19) Start marker is 0x7E; bytes sent unescaped, back to back, no gaps.
// (R20) Host hunts start marker, reads length, checks checksum, drops bad frames.
package rx_frame_pkg;

  localparam logic [31:0] OPTIONS_OFS   = 32'h0000_0000;
  localparam logic [31:0] LONG_HI_OFS   = 32'h0000_0004;
  localparam logic [31:0] LONG_LO_OFS   = 32'h0000_0008;
  localparam logic [31:0] SHORT_OFS     = 32'h0000_000C;
  localparam logic [31:0] ENDPOINT_OFS  = 32'h0000_0010;
  localparam logic [31:0] CLUSTER_OFS   = 32'h0000_0014;
  localparam logic [31:0] RXOPT_OFS     = 32'h0000_0018;
  localparam logic [31:0] PAYLOAD_OFS   = 32'h0000_001C;
  localparam logic [31:0] COMMAND_OFS   = 32'h0000_0020;
  localparam logic [31:0] STATUS_OFS    = 32'h0000_0024;
  localparam logic [31:0] COUNTS_OFS    = 32'h0000_0028;

  localparam int CMD_GO_BIT     = 0;
  localparam int CMD_DEVOBJ_BIT = 1;
  localparam int CMD_CLEAR_BIT  = 2;
  localparam int OPT_DEVOBJ_BIT = 0;
  localparam int OPT_DATA_BIT   = 1;

  localparam logic [7:0]  START_MARKER   = 8'h7E;
  localparam logic [7:0]  FRAME_TYPE     = 8'h91;
  localparam logic [7:0]  CHECKSUM_BASE  = 8'hFF;
  localparam logic [7:0]  VENDOR_EP_LO   = 8'hDC;
  localparam logic [7:0]  VENDOR_EP_HI   = 8'hEE;
  localparam logic [15:0] HEADER_LEN     = 16'h0012;
  localparam logic [15:0] TYPE_POS       = 16'h0003;
  localparam logic [15:0] OPTIONS_POS    = 16'h0014;
  localparam logic [15:0] PAYLOAD_POS    = 16'h0015;
  localparam logic [1:0]  OPTIONS_RESET  = 2'h0;

  typedef struct packed {
    logic [63:0] long_addr;
    logic [15:0] short_addr;
    logic [7:0]  src_ep;
    logic [7:0]  dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic [7:0]  options;
  } header_type;

endpackage : rx_frame_pkg

// file: rtl/explicit_receive_frame_builder.sv
// Explicit receive frame builder: AHB-Lite register slave and byte stream framer.
// Assumes a zero-wait AHB-Lite master and a byte sink with valid/ready on hclk.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
module explicit_receive_frame_builder
  import rx_frame_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             frame_busy
);

  localparam int IW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Length field is 16 bits, so header plus payload must fit
  if (DEPTH < 1 || DEPTH > 65535 - 18) begin : g_depth_check
    $error("DEPTH out of range");
  end

  header_type      hdr_q;
  logic [1:0]      out_opt_q;
  logic [7:0]      buf_q [DEPTH];
  logic [IW-1:0]   count_q;
  logic            overflow_q;
  logic [15:0]     sent_q;
  logic [15:0]     suppressed_q;
  logic            wr_q;
  logic [31:0]     addr_q;
  logic [31:0]     hrdata_q;
  logic [7:0]      tx_data_q;
  logic            tx_valid_q;
  logic [15:0]     pos_q;
  logic [7:0]      sum_q;

  logic            addr_phase;
  logic            wr_now;
  logic            go_req;
  logic            go_ok;
  logic            advance;
  logic [15:0]     len_w;
  logic [15:0]     last_pos;
  logic [15:0]     next_pos;
  logic [7:0]      next_byte;
  logic [7:0]      pay_byte;
  logic [15:0]     pay_idx;

  function automatic logic in_vendor_range(input logic [7:0] ep);
    in_vendor_range = (ep >= VENDOR_EP_LO) && (ep <= VENDOR_EP_HI);
  endfunction : in_vendor_range

  // Big-endian placement of every header field
  function automatic logic [7:0] frame_byte(input logic [15:0] p,
                                            input header_type h,
                                            input logic [15:0] len,
                                            input logic [7:0] pay,
                                            input logic [7:0] sum,
                                            input logic [15:0] last);
    logic [7:0] b;
    b = 8'h00;
    if (p == last) begin
      b = CHECKSUM_BASE - sum; // R15
    end else if (p >= PAYLOAD_POS) begin
      b = pay; // R14
    end else begin
      unique case (p[4:0])
        5'h00:   b = START_MARKER; // R2 R19
        5'h01:   b = len[15:8]; // R3 R18
        5'h02:   b = len[7:0]; // R3
        5'h03:   b = FRAME_TYPE; // R4
        5'h04:   b = h.long_addr[63:56]; // R5
        5'h05:   b = h.long_addr[55:48];
        5'h06:   b = h.long_addr[47:40];
        5'h07:   b = h.long_addr[39:32];
        5'h08:   b = h.long_addr[31:24];
        5'h09:   b = h.long_addr[23:16];
        5'h0A:   b = h.long_addr[15:8];
        5'h0B:   b = h.long_addr[7:0];
        5'h0C:   b = h.short_addr[15:8]; // R6
        5'h0D:   b = h.short_addr[7:0];
        5'h0E:   b = h.src_ep; // R7
        5'h0F:   b = h.dst_ep; // R7
        5'h10:   b = h.cluster[15:8]; // R8
        5'h11:   b = h.cluster[7:0];
        5'h12:   b = h.profile[15:8]; // R8
        5'h13:   b = h.profile[7:0];
        default: b = h.options; // R9 R10 R11 R12
      endcase
    end
    frame_byte = b;
  endfunction : frame_byte

  // Bus slave: zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_now     = wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      wr_q <= 1'b0;
      if (addr_phase) begin
        wr_q   <= hwrite;
        addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr)
        OPTIONS_OFS:  hrdata_q <= {30'h0000_0000, out_opt_q};
        LONG_HI_OFS:  hrdata_q <= hdr_q.long_addr[63:32];
        LONG_LO_OFS:  hrdata_q <= hdr_q.long_addr[31:0];
        SHORT_OFS:    hrdata_q <= {16'h0000, hdr_q.short_addr};
        ENDPOINT_OFS: hrdata_q <= {16'h0000, hdr_q.src_ep, hdr_q.dst_ep};
        CLUSTER_OFS:  hrdata_q <= {hdr_q.cluster, hdr_q.profile};
        RXOPT_OFS:    hrdata_q <= {24'h00_0000, hdr_q.options};
        PAYLOAD_OFS:  hrdata_q <= 32'(count_q);
        STATUS_OFS:   hrdata_q <= {27'h000_0000,
                                   hdr_q.options[7:6] == 2'b00, // R11
                                   in_vendor_range(hdr_q.src_ep), // R13
                                   in_vendor_range(hdr_q.dst_ep), // R13
                                   overflow_q, tx_valid_q};
        COUNTS_OFS:   hrdata_q <= {suppressed_q, sent_q};
        default:      hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Output options setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_opt_q <= OPTIONS_RESET;
    end else if (wr_now && addr_q == OPTIONS_OFS) begin
      out_opt_q <= hwdata[1:0];
    end
  end

  // Header fields, frozen while a frame is on the wire
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hdr_q <= '0;
    end else if (wr_now && !tx_valid_q) begin
      unique case (addr_q)
        LONG_HI_OFS:  hdr_q.long_addr[63:32] <= hwdata;
        LONG_LO_OFS:  hdr_q.long_addr[31:0]  <= hwdata;
        SHORT_OFS:    hdr_q.short_addr       <= hwdata[15:0];
        ENDPOINT_OFS: {hdr_q.src_ep, hdr_q.dst_ep} <= hwdata[15:0];
        CLUSTER_OFS:  {hdr_q.cluster, hdr_q.profile} <= hwdata;
        RXOPT_OFS:    hdr_q.options          <= hwdata[7:0]; // R12
        default:      hdr_q <= hdr_q;
      endcase
    end
  end

  // Payload store, appended one byte per write
  always_ff @(posedge hclk) begin
    if (wr_now && !tx_valid_q && addr_q == PAYLOAD_OFS && count_q < IW'(DEPTH)) begin
      buf_q[count_q[AW-1:0]] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q    <= '0;
      overflow_q <= 1'b0;
    end else if (wr_now && !tx_valid_q) begin
      if (addr_q == COMMAND_OFS && hwdata[CMD_CLEAR_BIT]) begin
        count_q    <= '0;
        overflow_q <= 1'b0;
      end else if (addr_q == PAYLOAD_OFS) begin
        if (count_q < IW'(DEPTH)) begin
          count_q <= count_q + IW'(1);
        end else begin
          overflow_q <= 1'b1;
        end
      end
    end
  end

  // Frame request and gating by output options
  assign go_req = wr_now && !tx_valid_q && addr_q == COMMAND_OFS && hwdata[CMD_GO_BIT]
                  && !hwdata[CMD_CLEAR_BIT];
  assign go_ok  = go_req && (hwdata[CMD_DEVOBJ_BIT] ? out_opt_q[OPT_DEVOBJ_BIT] // R16 R17
                                                    : out_opt_q[OPT_DATA_BIT]); // R1

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sent_q       <= 16'h0000;
      suppressed_q <= 16'h0000;
    end else if (go_req) begin
      if (go_ok) begin
        sent_q <= sent_q + 16'h0001;
      end else begin
        suppressed_q <= suppressed_q + 16'h0001;
      end
    end
  end

  // Byte stream
  assign len_w     = HEADER_LEN + 16'(count_q); // R3
  assign last_pos  = len_w + TYPE_POS;
  assign advance   = tx_valid_q && tx_ready;
  assign next_pos  = pos_q + 16'h0001;
  assign pay_idx   = next_pos - PAYLOAD_POS;
  assign pay_byte  = (pay_idx < 16'(DEPTH)) ? buf_q[pay_idx[AW-1:0]] : 8'h00;
  assign next_byte = frame_byte(next_pos, hdr_q, len_w, pay_byte, sum_q, last_pos);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      pos_q      <= 16'h0000;
      sum_q      <= 8'h00;
    end else if (go_ok) begin
      tx_valid_q <= 1'b1;
      tx_data_q  <= START_MARKER; // R2 R19
      pos_q      <= 16'h0000;
      sum_q      <= 8'h00;
    end else if (advance) begin
      if (pos_q == last_pos) begin
        tx_valid_q <= 1'b0;
      end else begin
        tx_data_q <= next_byte; // R19
        pos_q     <= next_pos;
        if (next_pos >= TYPE_POS && next_pos != last_pos) begin
          sum_q <= sum_q + next_byte; // R15
        end
      end
    end
  end

  assign tx_data    = tx_data_q;
  assign tx_valid   = tx_valid_q;
  assign frame_busy = tx_valid_q;

  start_marker_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    go_ok |=> tx_valid && tx_data == 8'h7E && pos_q == 16'h0000)
    else $error("frame did not open with start marker");

  gate_data_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    go_req && !hwdata[1] && !out_opt_q[1] |=> !tx_valid)
    else $error("data frame sent while disabled");

  gate_devobj_a: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    go_req && hwdata[1] && !out_opt_q[0] |=> !tx_valid)
    else $error("device-object frame sent while disabled");

  length_field_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    tx_valid && pos_q == 16'h0002 |-> {$past(tx_data, 1), tx_data} == 16'(count_q) + 16'h0012
      || !$past(tx_ready))
    else $error("length field wrong");

  frame_type_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    tx_valid && pos_q == 16'h0003 |-> tx_data == 8'h91)
    else $error("frame type wrong");

  options_byte_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    tx_valid && pos_q == 16'h0014 |-> tx_data == hdr_q.options)
    else $error("options byte wrong");

  payload_first_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    tx_valid && pos_q == 16'h0015 && count_q != '0 |-> tx_data == buf_q[0])
    else $error("payload not at offset 21");

  checksum_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    tx_valid && pos_q == last_pos |-> 8'(tx_data + sum_q) == 8'hFF)
    else $error("checksum wrong");

  hold_byte_a: assert property (@(posedge hclk) disable iff (!hresetn) // R19
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(pos_q))
    else $error("byte dropped under back-pressure");

  no_gap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R19
    tx_valid && tx_ready && pos_q != last_pos |=> tx_valid && pos_q == $past(pos_q) + 16'h0001)
    else $error("gap inside frame");

  end_frame_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    tx_valid && tx_ready && pos_q == last_pos |=> !tx_valid)
    else $error("frame overran its length");

endmodule : explicit_receive_frame_builder

// file: verification/frame_sink.sv
// Host model for the frame byte link: random stalls, start hunt, checksum test.
// Assumes the framer's valid/ready byte link on hclk.
module frame_sink (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       stall_en,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int         seed = 32'hFE9B8D5A;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_ready <= 1'b0;
    else tx_ready <= !stall_en || ($random(seed) % 2 != 0);
  end
  // Bytes before a start marker are dropped
  always @(posedge hclk) begin
    if (hresetn && tx_valid && tx_ready && (got.size() != 0 || tx_data == 8'h7E)) begin
      got.push_back(tx_data);
    end
  end
  // Length and checksum of the collected frame both hold
  function automatic logic frame_ok();
    logic [7:0] s;
    s = 8'h00;
    if (got.size() < 4) return 1'b0;
    for (int i = 3; i < got.size(); i++) s += got[i];
    return s == 8'hFF && got.size() == {got[1], got[2]} + 4;
  endfunction : frame_ok
endmodule : frame_sink

// file: verification/explicit_receive_frame_builder_tb_top.sv
// Random and corner frames through the builder, checked byte by byte.
// Assumes the single AHB-Lite slave answers with hreadyout; sink model on the link.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module explicit_receive_frame_builder_tb_top;
  import rx_frame_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] bytes_type[$];
  localparam int         DEPTH = 8;
  localparam logic [7:0] OPT_TBL [8] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h40, 8'h80, 8'hC0};
  localparam logic [7:0] EP_TBL [4] = '{8'hDB, 8'hDC, 8'hEE, 8'hEF};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_valid, tx_ready;
  logic        frame_busy, stall_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  tx_data;
  int          errors, total_checks, sent, supp, n;
  int          seed = 32'hFE9B8D5A;
  header_type  h;
  bytes_type   pay, exp_q;

  explicit_receive_frame_builder #(.DEPTH(DEPTH)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .frame_busy(frame_busy));
  frame_sink sink (.hclk(hclk), .hresetn(hresetn), .tx_data(tx_data), .tx_valid(tx_valid),
    .stall_en(stall_en), .tx_ready(tx_ready));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  function automatic bytes_type build(header_type x, bytes_type p);
    bytes_type   q;
    logic [7:0]  s;
    logic [15:0] len;
    len = 16'h0012 + 16'(p.size());
    q = {8'h7E, len[15:8], len[7:0], 8'h91};
    for (int i = 16; i >= 0; i--) q.push_back(x[i*8 +: 8]);
    q = {q, p};
    s = 8'h00;
    for (int i = 3; i < q.size(); i++) s += q[i];
    q.push_back(8'hFF - s);
    return q;
  endfunction : build

  function automatic logic vend(logic [7:0] e);
    return e >= 8'hDC && e <= 8'hEE;
  endfunction : vend

  // Status bits: invalid method, source in range, destination in range, overflow, busy
  function automatic logic [4:0] status_exp(header_type x, int cnt);
    return {x.options[7:6] == 2'b00, vend(x.src_ep), vend(x.dst_ep), cnt > DEPTH, 1'b0};
  endfunction : status_exp

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic frame(input logic [1:0] oset, input logic kind);
    int   k;
    logic ok;
    ok = kind ? oset[0] : oset[1];
    ahb(1'b1, 32'h00, {30'h0, oset});
    ahb(1'b1, 32'h04, h.long_addr[63:32]);
    ahb(1'b1, 32'h08, h.long_addr[31:0]);
    ahb(1'b1, 32'h0C, {16'h0, h.short_addr});
    ahb(1'b1, 32'h10, {16'h0, h.src_ep, h.dst_ep});
    ahb(1'b1, 32'h14, {h.cluster, h.profile});
    ahb(1'b1, 32'h18, {24'h0, h.options});
    ahb(1'b1, 32'h20, 32'h4);
    for (k = 0; k < pay.size(); k++) ahb(1'b1, 32'h1C, {24'h0, pay[k]});
    ahb(1'b0, 32'h24, 32'h0);
    `CHK(rd[4:0], status_exp(h, pay.size()))
    while (pay.size() > DEPTH) void'(pay.pop_back());
    ahb(1'b0, 32'h1C, 32'h0);
    `CHK(rd, 32'(pay.size()))
    exp_q = build(h, pay);
    sink.got.delete();
    ahb(1'b1, 32'h20, {30'h0, kind, 1'b1});
    if (ok) begin
      ahb(1'b1, 32'h04, ~h.long_addr[63:32]);
      ahb(1'b1, 32'h20, 32'h1);
    end
    k = 0;
    while ((frame_busy === 1'b1 || k < 2) && k < 4000) begin
      @(posedge hclk);
      k++;
    end
    `CHK(frame_busy, 1'b0)
    `CHK(sink.got.size(), ok ? exp_q.size() : 0)
    for (k = 0; ok && k < exp_q.size(); k++) `CHK(sink.got[k], exp_q[k])
    if (ok) `CHK(sink.frame_ok(), 1'b1)
    if (ok) sent++;
    else supp++;
  endtask : frame

  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    test_done();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; stall_en = 1'b0;
    errors = 0; total_checks = 0; sent = 0; supp = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h28, 32'h0);
    `CHK(rd, 32'h0)
    h = {64'h0013A20087654321, 16'h87BD, 8'hE8, 8'hE8, 16'h0011, 16'hC105, 8'h01};
    pay = {8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
    frame(2'h2, 1'b0);
    `CHK(sink.got[27], 8'h37)
    for (int i = 0; i < 40; i++) begin
      h = 136'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      if (i < 8) h.options = OPT_TBL[i];
      if (i < 4) h.src_ep = EP_TBL[i];
      if (i < 4) h.dst_ep = EP_TBL[3-i];
      n = (i == 4) ? 0 : (i == 5) ? DEPTH : (i == 6) ? DEPTH + 1 : {$random(seed)} % 10;
      pay.delete();
      repeat (n) pay.push_back(8'($random(seed)));
      stall_en <= ($random(seed) % 2 != 0);
      frame(i < 4 ? 2'(i) : 2'($random(seed)), i < 4 ? i[0] : 1'($random(seed)));
    end
    ahb(1'b0, 32'h28, 32'h0);
    `CHK(rd, {16'(supp), 16'(sent)})
    test_done();
  end
endmodule : explicit_receive_frame_builder_tb_top
